/* File: rtl/fvcb_pkg.sv */
package fvcb_pkg;

    // Register byte addresses
    localparam logic [7:0] FVCB_ADDR_IO_MODE   = 8'h00;
    localparam logic [7:0] FVCB_ADDR_DUMMY     = 8'h01;
    localparam logic [7:0] FVCB_ADDR_RSVD2     = 8'h02;
    localparam logic [7:0] FVCB_ADDR_DRIVE     = 8'h03;
    localparam logic [7:0] FVCB_ADDR_RSVD4     = 8'h04;
    localparam logic [7:0] FVCB_ADDR_ADDR_W    = 8'h05;
    localparam logic [7:0] FVCB_ADDR_EXEC      = 8'h06;
    localparam logic [7:0] FVCB_ADDR_WRAP      = 8'h07;
    localparam logic [7:0] FVCB_ADDR_RSVD8     = 8'h08;
    localparam logic [7:0] FVCB_ADDR_RSVD9     = 8'h09;
    localparam logic [7:0] FVCB_ADDR_TRAIN     = 8'h0A;
    localparam logic [7:0] FVCB_ADDR_INTEG     = 8'h0B;
    localparam int         FVCB_NUM_BYTES      = 12;

    // Reset values
    localparam logic [7:0] FVCB_RST_IO_MODE    = 8'hFF;
    localparam logic [7:0] FVCB_RST_DUMMY      = 8'h1F;
    localparam logic [7:0] FVCB_RST_DRIVE      = 8'hFF;
    localparam logic [7:0] FVCB_RST_ADDR_W     = 8'hFF;
    localparam logic [7:0] FVCB_RST_EXEC       = 8'hFF;
    localparam logic [7:0] FVCB_RST_WRAP       = 8'hFF;
    localparam logic [7:0] FVCB_RST_TRAIN      = 8'h55;
    localparam logic [7:0] FVCB_RST_INTEG      = 8'hFF;
    localparam logic [7:0] FVCB_RSVD_READ      = 8'hFF;

    // Integrity control field positions
    localparam int FVCB_BIT_RSVD7   = 7;
    localparam int FVCB_BIT_SW_PAT  = 6;
    localparam int FVCB_BIT_CRCSZ_H = 5;
    localparam int FVCB_BIT_CRCSZ_L = 4;
    localparam int FVCB_BIT_CRC_N   = 3;
    localparam int FVCB_BIT_ERRTYP  = 2;
    localparam int FVCB_BIT_ERROE_N = 1;
    localparam int FVCB_BIT_ECC_N   = 0;

    // Mode byte encodings
    localparam logic [7:0] FVCB_IO_EXT_DQS     = 8'hFF;
    localparam logic [7:0] FVCB_IO_EXT_NODQS   = 8'hDF;
    localparam logic [7:0] FVCB_IO_ODDR_DQS    = 8'hE7;
    localparam logic [7:0] FVCB_IO_ODDR_NODQS  = 8'hC7;
    localparam logic [7:0] FVCB_CODE_FF        = 8'hFF;
    localparam logic [7:0] FVCB_CODE_FE        = 8'hFE;
    localparam logic [7:0] FVCB_CODE_FD        = 8'hFD;
    localparam logic [7:0] FVCB_CODE_FC        = 8'hFC;
    localparam logic [7:0] FVCB_DUMMY_MIN      = 8'h01;
    localparam logic [7:0] FVCB_DUMMY_MAX      = 8'h1E;
    localparam logic [7:0] FVCB_DUMMY_DEF      = 8'h1F;
    localparam logic [7:0] FVCB_DUMMY_ZERO     = 8'h00;
    localparam logic [1:0] FVCB_CRC_32B        = 2'h2;
    localparam logic [1:0] FVCB_CRC_64B        = 2'h1;
    localparam logic [7:0] FVCB_CMD_READ_VCR   = 8'h85;

    typedef enum logic [1:0] {
        FVCB_IO_EXT      = 2'b00,
        FVCB_IO_EXT_NS   = 2'b01,
        FVCB_IO_OCT      = 2'b10,
        FVCB_IO_OCT_NS   = 2'b11
    } fvcb_io_e;

    typedef enum logic [1:0] {
        FVCB_WRAP_NONE   = 2'b00,
        FVCB_WRAP_64     = 2'b01,
        FVCB_WRAP_32     = 2'b10,
        FVCB_WRAP_16     = 2'b11
    } fvcb_wrap_e;

    typedef enum logic [1:0] {
        FVCB_DRV_50      = 2'b00,
        FVCB_DRV_35      = 2'b01,
        FVCB_DRV_25      = 2'b10,
        FVCB_DRV_18      = 2'b11
    } fvcb_drive_e;

    // Write port from the command decoder
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } fvcb_wr_s;

    // Decoded settings as seen by the rest of the device
    typedef struct packed {
        fvcb_io_e    io_mode;
        logic        octal_ddr;
        logic        strobe_en;
        logic [4:0]  dummy_cycles;
        logic        dummy_default;
        fvcb_drive_e drive;
        logic        addr_4byte;
        logic        execute_in_place;
        fvcb_wrap_e  wrap;
        logic [7:0]  training_pattern;
        logic        sso_pattern_select;
        logic        crc_chunk_64;
        logic        crc_parity_active;
        logic        error_type_select;
        logic        ecc_active;
        logic        error_output_active;
    } fvcb_cfg_s;

endpackage

/* File: rtl/fvcb_train_gen.sv */
`timescale 1ns/10ps
module fvcb_train_gen
    import fvcb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] pattern,
    input  wire logic       sso_pattern_select,
    input  wire logic [2:0] bit_index,
    output logic [7:0]      train_lines
);

    logic       pat_bit;        // Pattern bit for this beat
    logic [7:0] next_lines;     // Lines before the output register

    // Pick the pattern bit, MSB first
    assign pat_bit = pattern[3'h7 - bit_index];

    // Same bit on every line, line 3 flipped when sso_pattern_select is low
    always_comb begin
        next_lines = {8{pat_bit}};
        if (!sso_pattern_select) begin
            next_lines[3] = ~pat_bit;
        end
    end

    // Registered drive onto the data lines
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            train_lines <= 8'h00;
        end else begin
            train_lines <= next_lines;
        end
    end

endmodule

/* File: rtl/fvcb_decode.sv */
`timescale 1ns/10ps
module fvcb_decode
    import fvcb_pkg::*;
(
    input  wire logic [7:0] io_byte,
    input  wire logic [7:0] dummy_byte,
    input  wire logic [7:0] drive_byte,
    input  wire logic [7:0] addr_byte,
    input  wire logic [7:0] exec_byte,
    input  wire logic [7:0] wrap_byte,
    input  wire logic [7:0] train_byte,
    input  wire logic [7:0] integ_byte,
    output fvcb_cfg_s       cfg
);

    // Byte codes to decoded settings; reserved codes keep the default meaning
    always_comb begin
        cfg = '0;
        // Protocol and strobe
        case (io_byte)
            FVCB_IO_EXT_NODQS:  cfg.io_mode = FVCB_IO_EXT_NS;
            FVCB_IO_ODDR_DQS:   cfg.io_mode = FVCB_IO_OCT;
            FVCB_IO_ODDR_NODQS: cfg.io_mode = FVCB_IO_OCT_NS;
            default:            cfg.io_mode = FVCB_IO_EXT;
        endcase
        cfg.octal_ddr = cfg.io_mode[1];
        cfg.strobe_en = ~cfg.io_mode[0];
        // Dummy clocks: 1..30 explicit, 0 and 1F..FF mean command default
        if (dummy_byte >= FVCB_DUMMY_MIN && dummy_byte <= FVCB_DUMMY_MAX) begin
            cfg.dummy_cycles  = dummy_byte[4:0];
            cfg.dummy_default = 1'b0;
        end else begin
            cfg.dummy_cycles  = 5'h00;
            cfg.dummy_default = 1'b1;
        end
        // Output impedance
        case (drive_byte)
            FVCB_CODE_FE: cfg.drive = FVCB_DRV_35;
            FVCB_CODE_FD: cfg.drive = FVCB_DRV_25;
            FVCB_CODE_FC: cfg.drive = FVCB_DRV_18;
            default:      cfg.drive = FVCB_DRV_50;
        endcase
        cfg.addr_4byte       = (addr_byte == FVCB_CODE_FE);
        cfg.execute_in_place = (exec_byte == FVCB_CODE_FE);
        // Read wrap
        case (wrap_byte)
            FVCB_CODE_FE: cfg.wrap = FVCB_WRAP_64;
            FVCB_CODE_FD: cfg.wrap = FVCB_WRAP_32;
            FVCB_CODE_FC: cfg.wrap = FVCB_WRAP_16;
            default:      cfg.wrap = FVCB_WRAP_NONE;
        endcase
        cfg.training_pattern   = train_byte;
        cfg.sso_pattern_select = integ_byte[FVCB_BIT_SW_PAT];
        cfg.crc_chunk_64       = (integ_byte[FVCB_BIT_CRCSZ_H:FVCB_BIT_CRCSZ_L] == FVCB_CRC_64B);
        cfg.crc_parity_active  = ~integ_byte[FVCB_BIT_CRC_N] & cfg.octal_ddr;
        cfg.ecc_active         = ~integ_byte[FVCB_BIT_ECC_N];
        cfg.error_type_select  = integ_byte[FVCB_BIT_ERRTYP];
        cfg.error_output_active = ~integ_byte[FVCB_BIT_ERROE_N];
    end

endmodule

/* File: rtl/fvcb_bank.sv */
`timescale 1ns/10ps
// Contract
// - Low pattern select bit inverts data line three
// - Chunk field picks 32 or 64 bytes
// - Low CRC bit enables octal parity checks
// - Type bit picks error event reported
// - Low enable bit lets error pin act
// - Low ECC bit turns correction on
// - Training pattern byte, default 55h
// - Wrap byte selects continuous or wrap size
// - FEh enables execute-in-place, FFh disables
// - FEh selects four address bytes
// - Drive byte picks output impedance
// - Dummy byte sets clocks, 00h means default
// - Mode byte picks protocol and strobe
// - Read command returns addressed byte
module fvcb_bank
    import fvcb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire fvcb_wr_s   wr,
    input  wire logic       rd_en,
    input  wire logic [7:0] rd_addr,
    input  wire logic       cmd_start,
    input  wire logic [2:0] train_bit,
    input  wire logic       ecc_corr_evt,
    input  wire logic       ecc_det_evt,
    output logic [7:0]      rd_data,
    output logic            rd_valid,
    output fvcb_cfg_s       cfg,
    output logic [7:0]      train_lines,
    output logic            ecc_record_evt,
    output logic            error_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    ////////////////////////////////////////////////////////////////////////////

    logic [7:0] io_protocol_mode;        // Protocol mode byte
    logic [7:0] dummy_cycle_count;       // Dummy clock byte
    logic [7:0] output_drive_select;     // Output impedance byte
    logic [7:0] address_width_select;    // Address width byte
    logic [7:0] execute_in_place_enable; // Execute-in-place enable byte
    logic [7:0] read_wrap_select;        // Read wrap byte
    logic [7:0] training_pattern;        // Training pattern byte
    logic [6:0] integrity_control;       // Integrity control, bit 7 is fixed
    fvcb_cfg_s  next_cfg;                // Decoded from the bytes
    logic       sel_event;               // Selected ECC event

    // Address match helper, used by every write process
    function automatic logic hit(input fvcb_wr_s w, input logic [7:0] a);
        hit = w.en && (w.addr == a);
    endfunction

    // Protocol mode byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            io_protocol_mode <= FVCB_RST_IO_MODE;
        end else if (hit(wr, FVCB_ADDR_IO_MODE)) begin
            io_protocol_mode <= wr.data;
        end
    end

    // Dummy clock byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dummy_cycle_count <= FVCB_RST_DUMMY;
        end else if (hit(wr, FVCB_ADDR_DUMMY)) begin
            dummy_cycle_count <= wr.data;
        end
    end

    // Drive strength byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            output_drive_select <= FVCB_RST_DRIVE;
        end else if (hit(wr, FVCB_ADDR_DRIVE)) begin
            output_drive_select <= wr.data;
        end
    end

    // Address width byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            address_width_select <= FVCB_RST_ADDR_W;
        end else if (hit(wr, FVCB_ADDR_ADDR_W)) begin
            address_width_select <= wr.data;
        end
    end

    // Execute-in-place byte; entry itself needs the host confirmation in a read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            execute_in_place_enable <= FVCB_RST_EXEC;
        end else if (hit(wr, FVCB_ADDR_EXEC)) begin
            execute_in_place_enable <= wr.data;
        end
    end

    // Wrap byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            read_wrap_select <= FVCB_RST_WRAP;
        end else if (hit(wr, FVCB_ADDR_WRAP)) begin
            read_wrap_select <= wr.data;
        end
    end

    // Training pattern byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            training_pattern <= FVCB_RST_TRAIN;
        end else if (hit(wr, FVCB_ADDR_TRAIN)) begin
            training_pattern <= wr.data;
        end
    end

    // Integrity control; the top bit is not stored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            integrity_control <= FVCB_RST_INTEG[6:0];
        end else if (hit(wr, FVCB_ADDR_INTEG)) begin
            integrity_control <= wr.data[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode and apply
    ////////////////////////////////////////////////////////////////////////////

    // Byte codes into settings
    fvcb_decode u_decode (
        .io_byte    (io_protocol_mode),
        .dummy_byte (dummy_cycle_count),
        .drive_byte (output_drive_select),
        .addr_byte  (address_width_select),
        .exec_byte  (execute_in_place_enable),
        .wrap_byte  (read_wrap_select),
        .train_byte (training_pattern),
        .integ_byte ({1'b1, integrity_control}),
        .cfg        (next_cfg)
    );

    // Settings latch at command start so a command never sees a change midway
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= '0;
            cfg.dummy_default      <= 1'b1;
            cfg.strobe_en          <= 1'b1;
            cfg.training_pattern   <= FVCB_RST_TRAIN;
            cfg.sso_pattern_select <= 1'b1;
            cfg.error_type_select  <= 1'b1;
        end else if (cmd_start) begin
            cfg <= next_cfg;
        end
    end

    // Training lines from the latched settings
    fvcb_train_gen u_train (
        .clk                (clk),
        .arst_n             (arst_n),
        .pattern            (cfg.training_pattern),
        .sso_pattern_select (cfg.sso_pattern_select),
        .bit_index          (train_bit),
        .train_lines        (train_lines)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Error reporting
    ////////////////////////////////////////////////////////////////////////////

    // Event picked by the type bit, only while ECC runs
    assign sel_event = cfg.ecc_active &&
                       (cfg.error_type_select ? ecc_det_evt : ecc_corr_evt);

    // Tells the chunk address recorder which event to capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ecc_record_evt <= 1'b0;
        end else begin
            ecc_record_evt <= sel_event;
        end
    end

    // Error pin low on the selected event when its output is enabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            error_n <= 1'b1;
        end else begin
            error_n <= ~(sel_event && cfg.error_output_active);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read back
    ////////////////////////////////////////////////////////////////////////////

    // Addressed byte one cycle after the read strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                case (rd_addr)
                    FVCB_ADDR_IO_MODE: rd_data <= io_protocol_mode;
                    FVCB_ADDR_DUMMY:   rd_data <= dummy_cycle_count;
                    FVCB_ADDR_DRIVE:   rd_data <= output_drive_select;
                    FVCB_ADDR_ADDR_W:  rd_data <= address_width_select;
                    FVCB_ADDR_EXEC:    rd_data <= execute_in_place_enable;
                    FVCB_ADDR_WRAP:    rd_data <= read_wrap_select;
                    FVCB_ADDR_TRAIN:   rd_data <= training_pattern;
                    FVCB_ADDR_INTEG:   rd_data <= {1'b1, integrity_control};
                    default:           rd_data <= FVCB_RSVD_READ;
                endcase
            end
        end
    end

endmodule

/* File: tb/fvcb_bank_asserts.sv */
`timescale 1ns/10ps
module fvcb_bank_asserts
    import fvcb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire fvcb_wr_s   wr,
    input  wire logic       rd_en,
    input  wire logic [7:0] rd_addr,
    input  wire logic       cmd_start,
    input  wire logic [2:0] train_bit,
    input  wire logic       ecc_corr_evt,
    input  wire logic       ecc_det_evt,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    input  wire fvcb_cfg_s  cfg,
    input  wire logic [7:0] train_lines,
    input  wire logic       ecc_record_evt,
    input  wire logic       error_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////
    // Helpers: reserved read place, expected training lines
    logic       rsvd_rd;
    logic [7:0] exp_lines;
    assign rsvd_rd   = rd_en && (rd_addr inside {8'h02, 8'h04, 8'h08, 8'h09} || rd_addr > 8'h0B);
    assign exp_lines = {8{cfg.training_pattern[3'h7 - train_bit]}} ^ {4'h0, !cfg.sso_pattern_select, 3'h0};

    ////////////////////////////////////////////////////////////////
    // Read port answers
    a_read_answer: assert property (rd_en |=> rd_valid)
        else $error("read strobe gave no valid");
    a_no_spurious: assert property (!rd_en |=> !rd_valid && $stable(rd_data))
        else $error("read answer without strobe");
    a_rsvd_reads: assert property (rsvd_rd |=> rd_data == 8'hFF)
        else $error("reserved byte not all ones");
    a_integ_top: assert property (rd_en && rd_addr == 8'h0B |=> rd_data[7])
        else $error("integrity top bit not one");
    // Settings move only at a command start
    a_cfg_stable: assert property (!cmd_start |=> $stable(cfg))
        else $error("settings changed without command");
    a_crc_octal: assert property (cfg.crc_parity_active |-> cfg.octal_ddr)
        else $error("parity active outside octal mode");
    // Error pin and recorder
    a_ecc_off: assert property (!cfg.ecc_active |=> !ecc_record_evt && error_n)
        else $error("error event with correction off");
    a_err_gate: assert property (!cfg.error_output_active |=> error_n)
        else $error("error pin active while disabled");
    a_det_record: assert property (cfg.ecc_active && cfg.error_type_select && ecc_det_evt |=> ecc_record_evt)
        else $error("detection event not recorded");
    a_corr_record: assert property (cfg.ecc_active && !cfg.error_type_select && ecc_corr_evt |=> ecc_record_evt)
        else $error("correction event not recorded");
    a_train_lines: assert property (1'b1 |=> train_lines == $past(exp_lines))
        else $error("training lines wrong");
endmodule

bind fvcb_bank fvcb_bank_asserts u_asserts (.clk(clk), .arst_n(arst_n), .wr(wr), .rd_en(rd_en),
    .rd_addr(rd_addr), .cmd_start(cmd_start), .train_bit(train_bit), .ecc_corr_evt(ecc_corr_evt),
    .ecc_det_evt(ecc_det_evt), .rd_data(rd_data), .rd_valid(rd_valid), .cfg(cfg),
    .train_lines(train_lines), .ecc_record_evt(ecc_record_evt), .error_n(error_n));

/* File: tb/fvcb_host.sv */
`timescale 1ns/10ps
module fvcb_host
    import fvcb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output fvcb_wr_s        wr,
    output logic            rd_en,
    output logic [7:0]      rd_addr,
    output logic            cmd_start
);
    // Idle bus at time zero
    initial begin
        wr = '0;
        rd_en = 1'b0;
        rd_addr = 8'h00;
        cmd_start = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Byte write: one strobe cycle, released at the next falling edge
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = '{en: 1'b1, addr: a, data: d};
        @(negedge clk);
        wr.en = 1'b0;
    endtask

    // Byte read: answer taken one cycle after the strobe
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        d = rd_data;
        v = rd_valid;
        rd_en = 1'b0;
    endtask

    // New command; one cmd_start strobe cycle, released at the next falling edge
    task automatic cmd();
        @(negedge clk);
        cmd_start = 1'b1;
        @(negedge clk);
        cmd_start = 1'b0;
    endtask
endmodule

/* File: tb/fvcb_bank_bench.sv */
`timescale 1ns/10ps
module fvcb_bank_bench
    import fvcb_pkg::*;
;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    fvcb_wr_s   wr;
    logic       rd_en, cmd_start, ecc_corr_evt, ecc_det_evt, rd_valid, ecc_record_evt, error_n;
    logic [7:0] rd_addr, rd_data, train_lines;
    logic [2:0] train_bit;
    fvcb_cfg_s  cfg, ecfg;
    int         mismatches = 0;
    int         n_compared = 0;
    logic [7:0] mem [16];
    logic [31:0] rs = 32'h2B81;
    logic [31:0] r;
    logic [7:0] io_c [5] = '{8'hDF, 8'hE7, 8'hC7, 8'hFF, 8'h12};
    logic [7:0] dm_c [5] = '{8'h00, 8'h01, 8'h1E, 8'h1F, 8'h20};
    logic [7:0] cd_c [5] = '{8'hFE, 8'hFD, 8'hFC, 8'hFF, 8'h00};
    logic [7:0] ig_c [5] = '{8'hA5, 8'hF7, 8'h5A, 8'h00, 8'hFF};

    always #12.5 clk = ~clk;

    fvcb_host HOST (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .wr(wr), .rd_en(rd_en),
        .rd_addr(rd_addr), .cmd_start(cmd_start));
    fvcb_bank DUT (.clk(clk), .arst_n(arst_n), .wr(wr), .rd_en(rd_en), .rd_addr(rd_addr),
        .cmd_start(cmd_start), .train_bit(train_bit), .ecc_corr_evt(ecc_corr_evt),
        .ecc_det_evt(ecc_det_evt), .rd_data(rd_data), .rd_valid(rd_valid), .cfg(cfg),
        .train_lines(train_lines), .ecc_record_evt(ecc_record_evt), .error_n(error_n));

    ////////////////////////////////////////////////////////////////
    // Xorshift source
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // Reference decode of the byte model
    function automatic fvcb_cfg_s dec();
        fvcb_cfg_s c;
        c = '0;
        case (mem[0])
            8'hDF:   c.io_mode = FVCB_IO_EXT_NS;
            8'hE7:   c.io_mode = FVCB_IO_OCT;
            8'hC7:   c.io_mode = FVCB_IO_OCT_NS;
            default: c.io_mode = FVCB_IO_EXT;
        endcase
        c.octal_ddr = mem[0] inside {8'hE7, 8'hC7};
        c.strobe_en = !(mem[0] inside {8'hDF, 8'hC7});
        c.dummy_default = !(mem[1] inside {[8'h01:8'h1E]});
        c.dummy_cycles = c.dummy_default ? 5'h00 : mem[1][4:0];
        c.drive = (mem[3] >= 8'hFC) ? fvcb_drive_e'(~mem[3][1:0]) : FVCB_DRV_50;
        c.addr_4byte = mem[5] == 8'hFE;
        c.execute_in_place = mem[6] == 8'hFE;
        c.wrap = (mem[7] >= 8'hFC) ? fvcb_wrap_e'(~mem[7][1:0]) : FVCB_WRAP_NONE;
        c.training_pattern = mem[10];
        c.sso_pattern_select = mem[11][6];
        c.crc_chunk_64 = mem[11][5:4] == 2'b01;
        c.crc_parity_active = !mem[11][3] && c.octal_ddr;
        c.error_type_select = mem[11][2];
        c.ecc_active = !mem[11][0];
        c.error_output_active = !mem[11][1];
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Compare, verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Counts: %0d compared, %0d mismatches", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Write through host and into the model; refused places stay ones
    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        HOST.wr_byte(a, d);
        if (a inside {8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0A})
            mem[a[3:0]] = d;
        else if (a == 8'h0B)
            mem[11] = {1'b1, d[6:0]};
    endtask

    task automatic mrd(input logic [7:0] a);
        logic [7:0] d;
        logic       v;
        HOST.rd_byte(a, d, v);
        chk(v, 1);
        chk(d, (a < 8'h10) ? mem[a[3:0]] : 8'hFF);
    endtask

    task automatic mcmd();
        chk(cfg, ecfg);
        HOST.cmd();
        ecfg = dec();
        chk(cfg, ecfg);
    endtask

    // One ECC event pair, answer one cycle later
    task automatic ecc_ev(input logic [1:0] e);
        logic rec;
        @(negedge clk);
        {ecc_det_evt, ecc_corr_evt} = e;
        rec = ecfg.ecc_active && (ecfg.error_type_select ? e[1] : e[0]);
        @(negedge clk);
        {ecc_det_evt, ecc_corr_evt} = 2'b00;
        chk(ecc_record_evt, rec);
        chk(error_n, !(rec && ecfg.error_output_active));
    endtask

    ////////////////////////////////////////////////////////////////
    // Reset for 8 cycles, reload the model with defaults, read every byte back
    task automatic do_reset();
        @(negedge clk) arst_n = 1'b0;
        for (int i = 0; i < 16; i++)
            mem[i] = 8'hFF;
        mem[1] = 8'h1F;
        mem[10] = 8'h55;
        ecfg = dec();
        repeat (8) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        chk(cfg, ecfg);
        for (int a = 0; a < 16; a++)
            mrd(a[7:0]);
        mrd(8'hF0);
    endtask

    // Main sequence
    initial begin
        train_bit = 3'h0;
        ecc_corr_evt = 1'b0;
        ecc_det_evt = 1'b0;
        do_reset();
        $display("reset defaults test done");
        for (int k = 0; k < 5; k++) begin
            mwr(8'h00, io_c[k]);
            mwr(8'h01, dm_c[k]);
            mwr(8'h03, cd_c[k]);
            mwr(8'h05, cd_c[k]);
            mwr(8'h06, cd_c[k]);
            mwr(8'h07, cd_c[k]);
            mwr(8'h0B, ig_c[k]);
            mcmd();
        end
        $display("code table test done");
        for (int i = 0; i < 40; i++) begin
            r = xs();
            mwr({4'h0, r[3:0]}, r[15:8]);
            mrd({4'h0, r[19:16]});
        end
        mcmd();
        $display("random access test done");
        for (int k = 0; k < 8; k++) begin
            mwr(8'h0B, {5'h1F, k[2:0]});
            mcmd();
            for (int e = 0; e < 4; e++)
                ecc_ev(e[1:0]);
        end
        $display("error pin test done");
        for (int s = 0; s < 2; s++) begin
            r = xs();
            mwr(8'h0A, r[7:0]);
            mwr(8'h0B, {1'b1, s[0], 6'h3F});
            mcmd();
            for (int b = 0; b < 8; b++) begin
                @(negedge clk) train_bit = b[2:0];
                @(negedge clk);
                chk(train_lines, {8{r[7 - b]}} ^ (s[0] ? 8'h00 : 8'h08));
            end
        end
        $display("training test done");
        do_reset();
        $display("mid-run reset test done");
        test_done();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("Error %0t: watchdog expired", $time);
        test_done();
    end
endmodule
